/* File: ddi_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ddi_host_model (
  // Clock
  input  wire logic       clk_i,
  // Host lines, low active apart from dir_o
  output logic [3:0]      sel_n_o,
  output logic            step_n_o,
  output logic            dir_o,
  output logic            wdata_n_o,
  output logic            wgate_n_o
);
  initial begin
    sel_n_o   = 4'hf;
    step_n_o  = 1'b1;
    dir_o     = 1'b0;
    wdata_n_o = 1'b1;
    wgate_n_o = 1'b1;
  end

  task automatic drive(input logic [3:0] sel, input logic gate);
    @(posedge clk_i);
    sel_n_o   <= sel;
    wgate_n_o <= gate;
  endtask

  // Direction settles before the pulse, pulse held well past 1 us
  task automatic do_step(input logic d);
    @(posedge clk_i);
    dir_o <= d;
    repeat (22) @(posedge clk_i);
    step_n_o <= 1'b0;
    repeat (24) @(posedge clk_i);
    step_n_o <= 1'b1;
    repeat (10) @(posedge clk_i);
  endtask

  task automatic wr_edge();
    @(posedge clk_i);
    wdata_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wdata_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: ddi_pkg.sv */
`default_nettype none
package ddi_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam real CLK_MHZ         = 20.0;
  localparam real REV_PERIOD_MS   = 166.67;
  localparam real IDX_BASE_MS     = 1.8;
  localparam real IDX_SEP_MS      = 0.4;
  localparam real SECTOR_MS       = 0.4;
  localparam real POR_MS          = 90.0;
  localparam real STEP_MIN_US     = 1.0;

  // Pulse widths are rounded down, hold, timeout and step figures up, with no lower limit of one cycle
  localparam int  IDX_BASE_CYC    = int'($floor(IDX_BASE_MS * 1000.0 * CLK_MHZ));
  localparam int  IDX_SEP_CYC     = int'($floor(IDX_SEP_MS * 1000.0 * CLK_MHZ));
  localparam int  SECTOR_CYC      = int'($floor(SECTOR_MS * 1000.0 * CLK_MHZ));
  localparam int  POR_CYC         = int'($ceil(POR_MS * 1000.0 * CLK_MHZ));
  localparam int  ROT_TIMEOUT_CYC = int'($ceil(2.0 * REV_PERIOD_MS * 1000.0 * CLK_MHZ));
  localparam int  STEP_MIN_CYC    = int'($ceil(STEP_MIN_US * CLK_MHZ));

  // ****************************************************************
  // Widths and limits
  // ****************************************************************
  localparam int       PW_W        = 16;
  localparam int       POR_W       = 21;
  localparam int       ROT_W       = 23;
  localparam int       TRK_W       = 7;
  localparam logic [TRK_W-1:0] TRACK_MAX = 7'h4c;
  localparam logic [TRK_W-1:0] TRACK_RST = 7'h00;
  localparam logic [1:0]       PHASE_I   = 2'h0;
  localparam logic [1:0]       HOLES_RDY = 2'h2;

  // ****************************************************************
  // Pin carrier, raw levels as seen on the connector
  // ****************************************************************
  typedef struct packed {
    logic [3:0] sel_n;
    logic [1:0] unit_addr;
    logic       sep_variant;
    logic       step_n;
    logic       dir_out;
    logic       wdata_n;
    logic       wgate_n;
    logic       side0;
    logic       idx_hole_n;
    logic       sec_hole_n;
    logic       disk_in_n;
    logic       prot_notch_n;
    logic       two_sided_n;
  } ddi_pins_t;

  localparam ddi_pins_t PINS_RST = '{sel_n: 4'hf, unit_addr: 2'h0,
                                     sep_variant: 1'b0, default: 1'b1};

  // Drive-side status, carried to the output flops
  typedef struct packed {
    logic index_n;
    logic ready_n;
    logic sector_n;
    logic track00_n;
    logic wr_lock_n;
  } ddi_status_t;

  localparam ddi_status_t STATUS_RST = '1;

endpackage
`default_nettype wire

/* File: ddi_top.sv */
// What this block does, and what its host must do
// [R1] Index output low once per spindle revolution
// [R2] Index width 1.8 ms base, 0.4 ms separator
// [R3] Host trusts index edge only after selecting
// [R4] Ready needs rotation, two holes, own select
// [R5] After power reset, ready follows two holes
// [R6] Single-sided disk: ready only on surface 0
// [R7] Separator variant: 0.4 ms sector pulses
// [R8] Respond only to jumper-matched select line
// [R9] Select loads head, powers stepper, enables I/O
// [R10] Direction low steps inward, high outward
// [R11] One track per step rising edge
// [R12] Host holds step low at least 1 us
// [R13] Host sets direction 1 us before edge
// [R14] Write gate enables data; fall reverses current
// [R15] Gate low writes; high enables read, stepping
// [R16] Track zero output needs track 00, phase I
// [R17] Uncovered notch: lock output low, no writing
// [R18] Side input low surface 1, high surface 0
// [R19] Power reset 90 ms inhibits writing
// [R20] Host inputs synchronised, step edge on them
// [R21] Track counter clamped at zero drives status
`timescale 1ns/10ps
`default_nettype none
module ddi_top
  import ddi_pkg::*;
#(
  parameter int unsigned IDX_BASE_CYC_P = IDX_BASE_CYC,
  parameter int unsigned IDX_SEP_CYC_P  = IDX_SEP_CYC,
  parameter int unsigned SECTOR_CYC_P   = SECTOR_CYC,
  parameter int unsigned POR_CYC_P      = POR_CYC,
  parameter int unsigned ROT_TMO_CYC_P  = ROT_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic             REF_CLK_I,
  input  wire logic             RST_N_I,
  // Host interface and mechanism sensors
  input  wire ddi_pins_t        PINS_I,
  // Host status outputs, low active
  output var  ddi_status_t      STATUS_O,
  // Mechanism controls
  output logic                  HEAD_LOAD_O,
  output logic                  STEPPER_PWR_O,
  output logic [1:0]            STEP_PHASE_O,
  output logic [TRK_W-1:0]      TRACK_O,
  output logic                  ACTIVITY_INDICATOR_O,
  output logic                  DOOR_LOCK_O,
  output logic                  READ_ENABLE_O,
  output logic                  WRITE_ENABLE_O,
  output logic                  WRITE_CURRENT_O
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  ddi_pins_t        s1_r;
  ddi_pins_t        s2_r;
  ddi_pins_t        s3_r;
  ddi_pins_t        pin_r;
  ddi_pins_t        pin_d_r;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      s1_r    <= PINS_RST;
      s2_r    <= PINS_RST;
      s3_r    <= PINS_RST;
      pin_r   <= PINS_RST;
      pin_d_r <= PINS_RST;
    end else begin
      s1_r    <= PINS_I;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      // A bit rises when the second and third stage are both high, clears when they differ
      pin_r   <= (s2_r & s3_r) | (pin_r & ~(s2_r ^ s3_r)); // [R20]
      pin_d_r <= pin_r;
    end
  end

  function automatic logic fell(input logic now, input logic was);
    fell = was & ~now;
  endfunction

  logic             sel;
  logic             disk_in;
  logic             por_busy;
  logic             step_ok;
  logic             step_rise;
  logic             wr_en;

  // Only the line named by the address jumpers is heeded
  assign sel     = ~pin_r.sel_n[pin_r.unit_addr]; // [R8]
  assign disk_in = ~pin_r.disk_in_n;
  // Step edge taken from the filtered copy, low to high
  assign step_rise = pin_r.step_n & ~pin_d_r.step_n; // [R11] [R20]
  assign step_ok   = sel & pin_r.wgate_n & ~por_busy; // [R15]
  assign wr_en     = sel & ~pin_r.wgate_n & ~por_busy & disk_in
                     & pin_r.prot_notch_n; // [R14] [R17] [R19]

  // ****************************************************************
  // Power-on hold
  // ****************************************************************
  logic [POR_W-1:0] por_cnt_r;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      por_cnt_r <= POR_W'(POR_CYC_P);
    end else if (por_cnt_r != '0) begin
      por_cnt_r <= por_cnt_r - 1'b1; // [R19]
    end
  end

  assign por_busy = (por_cnt_r != '0);

  // ****************************************************************
  // Rotation and hole count
  // ****************************************************************
  logic [ROT_W-1:0] rot_cnt_r;
  logic [1:0]       holes_r;
  logic             hole_fall;
  logic             rotating;

  assign hole_fall = fell(pin_r.idx_hole_n, pin_d_r.idx_hole_n);
  assign rotating  = (rot_cnt_r < ROT_W'(ROT_TMO_CYC_P));

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      rot_cnt_r <= ROT_W'(ROT_TMO_CYC_P);
    end else if (!disk_in) begin
      rot_cnt_r <= ROT_W'(ROT_TMO_CYC_P);
    end else if (hole_fall) begin
      rot_cnt_r <= '0;
    end else if (rotating) begin
      rot_cnt_r <= rot_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      holes_r <= 2'h0;
    end else if (por_busy || !disk_in || (!rotating && !hole_fall)) begin
      holes_r <= 2'h0; // [R5]
    end else if (hole_fall && holes_r != HOLES_RDY) begin
      holes_r <= holes_r + 1'b1; // [R4]
    end
  end

  // ****************************************************************
  // Index and sector pulse timers
  // ****************************************************************
  logic [PW_W-1:0]  idx_cnt_r;
  logic [PW_W-1:0]  sec_cnt_r;
  logic [PW_W-1:0]  idx_width;
  logic             sec_fall;

  assign idx_width = pin_r.sep_variant ? PW_W'(IDX_SEP_CYC_P)
                                       : PW_W'(IDX_BASE_CYC_P); // [R2]
  assign sec_fall  = fell(pin_r.sec_hole_n, pin_d_r.sec_hole_n);

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      idx_cnt_r <= '0;
    end else if (hole_fall && disk_in) begin
      idx_cnt_r <= idx_width; // [R1]
    end else if (idx_cnt_r != '0) begin
      idx_cnt_r <= idx_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      sec_cnt_r <= '0;
    end else if (sec_fall && disk_in && pin_r.sep_variant) begin
      sec_cnt_r <= PW_W'(SECTOR_CYC_P); // [R7]
    end else if (sec_cnt_r != '0) begin
      sec_cnt_r <= sec_cnt_r - 1'b1;
    end
  end

  // ****************************************************************
  // Head positioning
  // ****************************************************************
  logic [TRK_W-1:0] track_r;
  logic [1:0]       phase_r;
  logic             step_in;
  logic             step_out;

  assign step_in  = step_rise & step_ok & ~pin_r.dir_out & (track_r != TRACK_MAX);
  assign step_out = step_rise & step_ok & pin_r.dir_out & (track_r != TRACK_RST);

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      track_r <= TRACK_RST;
    end else if (step_in) begin
      track_r <= track_r + 1'b1; // [R10] [R11] [R21]
    end else if (step_out) begin
      track_r <= track_r - 1'b1; // [R10] [R11] [R21]
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      phase_r <= PHASE_I;
    end else if (step_in) begin
      phase_r <= phase_r + 1'b1;
    end else if (step_out) begin
      phase_r <= phase_r - 1'b1;
    end
  end

  // ****************************************************************
  // Write current
  // ****************************************************************
  logic             wcur_r;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      wcur_r <= 1'b0;
    end else if (wr_en && fell(pin_r.wdata_n, pin_d_r.wdata_n)) begin
      wcur_r <= ~wcur_r; // [R14]
    end
  end

  // ****************************************************************
  // Output flops
  // ****************************************************************
  ddi_status_t      status_nxt;
  logic             surface_ok;

  // Side input high picks surface 0; a one-sided disk has no surface 1
  assign surface_ok = pin_r.side0 | ~pin_r.two_sided_n; // [R6] [R18]

  always_comb begin
    status_nxt           = STATUS_RST;
    status_nxt.index_n   = ~(sel & (idx_cnt_r != '0)); // [R1] [R9]
    status_nxt.ready_n   = ~(sel & disk_in & rotating & (holes_r == HOLES_RDY)
                             & surface_ok); // [R4] [R6]
    status_nxt.sector_n  = ~(sel & (sec_cnt_r != '0)); // [R7]
    status_nxt.track00_n = ~(sel & (track_r == TRACK_RST)
                             & (phase_r == PHASE_I)); // [R16] [R21]
    status_nxt.wr_lock_n = ~(sel & disk_in & ~pin_r.prot_notch_n); // [R17]
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      STATUS_O             <= STATUS_RST;
      HEAD_LOAD_O          <= 1'b0;
      STEPPER_PWR_O        <= 1'b0;
      ACTIVITY_INDICATOR_O <= 1'b0;
      DOOR_LOCK_O          <= 1'b0;
      READ_ENABLE_O        <= 1'b0;
      WRITE_ENABLE_O       <= 1'b0;
    end else begin
      STATUS_O             <= status_nxt;
      HEAD_LOAD_O          <= sel; // [R9]
      STEPPER_PWR_O        <= sel; // [R9]
      ACTIVITY_INDICATOR_O <= sel; // [R9]
      DOOR_LOCK_O          <= sel; // [R9]
      READ_ENABLE_O        <= sel & pin_r.wgate_n; // [R15]
      WRITE_ENABLE_O       <= wr_en; // [R14] [R19]
    end
  end

  assign STEP_PHASE_O    = phase_r;
  assign TRACK_O         = track_r;
  assign WRITE_CURRENT_O = wcur_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  deselect_quiet_a: assert property ( // [R8] [R9]
    !sel |=> STATUS_O == STATUS_RST && !HEAD_LOAD_O && !DOOR_LOCK_O)
    else $error("deselected drive drove an output");

  ready_cause_a: assert property ( // [R4] [R6]
    !status_nxt.ready_n |-> holes_r == HOLES_RDY && rotating
                            && (pin_r.side0 || !pin_r.two_sided_n))
    else $error("ready without its conditions");

  step_in_a: assert property ( // [R10] [R11]
    step_rise && step_ok && !pin_r.dir_out && track_r < TRACK_MAX
    |=> track_r == $past(track_r) + 7'h01)
    else $error("inward step did not add one track");

  step_out_a: assert property ( // [R10] [R21]
    step_rise && step_ok && pin_r.dir_out && track_r != TRACK_RST
    |=> track_r == $past(track_r) - 7'h01)
    else $error("outward step did not remove one track");

  track_hold_a: assert property ( // [R11] [R15]
    !(step_rise && step_ok) |=> $stable(track_r))
    else $error("track moved without a step edge");

  track_zero_a: assert property ( // [R16]
    sel && track_r == TRACK_RST && phase_r == PHASE_I |=> !STATUS_O.track00_n)
    else $error("track zero not reported");

  wr_flip_a: assert property ( // [R14]
    wr_en && pin_d_r.wdata_n && !pin_r.wdata_n |=> WRITE_CURRENT_O != $past(WRITE_CURRENT_O))
    else $error("write current did not reverse");

  wr_lock_a: assert property ( // [R17] [R19]
    (!pin_r.prot_notch_n || por_busy) |=> !WRITE_ENABLE_O ##0 $stable(WRITE_CURRENT_O))
    else $error("write allowed while locked");

  idx_width_a: assert property ( // [R1] [R2]
    $rose(idx_cnt_r != '0) |-> idx_cnt_r == idx_width)
    else $error("index pulse width wrong");

  sector_src_a: assert property ( // [R7]
    $rose(sec_cnt_r != '0) |-> pin_r.sep_variant && sec_cnt_r == PW_W'(SECTOR_CYC_P))
    else $error("sector pulse wrong");

  sel_drive_a: assert property ( // [R9]
    sel |=> HEAD_LOAD_O && STEPPER_PWR_O && ACTIVITY_INDICATOR_O && DOOR_LOCK_O)
    else $error("selected drive left a control off");

  por_hold_a: assert property ( // [R19]
    por_busy |=> !WRITE_ENABLE_O && $stable(track_r) && holes_r == 2'h0)
    else $error("power hold let the drive act");

  index_out_a: assert property ( // [R1]
    sel && idx_cnt_r != '0 |=> !STATUS_O.index_n)
    else $error("index pulse not shown");

  no_disk_a: assert property ( // [R4]
    !disk_in |=> STATUS_O.ready_n && STATUS_O.wr_lock_n && !WRITE_ENABLE_O)
    else $error("status claimed a diskette");

  sector_only_a: assert property ( // [R7]
    !pin_r.sep_variant && sec_cnt_r == '0 |=> STATUS_O.sector_n)
    else $error("sector pulse on base variant");

  read_path_a: assert property ( // [R15]
    sel && pin_r.wgate_n |=> READ_ENABLE_O && !WRITE_ENABLE_O)
    else $error("gate high did not select reading");

  ready_c: cover property (!status_nxt.ready_n ##1 !STATUS_O.index_n);
  step_c:  cover property (step_in ##[1:200] step_out);
  write_c: cover property (wr_en ##1 $changed(WRITE_CURRENT_O));
  zero_c:  cover property (step_out ##1 track_r == TRACK_RST);

endmodule
`default_nettype wire

/* File: ddi_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module ddi_top_bench;
  import ddi_pkg::*;
  localparam int IB = 40;
  localparam int IS = 20;
  localparam int SC = 20;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [1:0]       ua = 2'h2;
  logic             sep = 1'b0;
  logic             idx_n = 1'b1;
  logic             dsk_n = 1'b0;
  logic             ntc_n = 1'b1;
  logic             two_n = 1'b1;
  logic             side0 = 1'b1;
  logic [3:0]       h_sel;
  logic             h_stp, h_dir, h_wd, h_wg;
  ddi_pins_t        pins;
  ddi_status_t      st;
  logic [3:0]       ctl;
  logic [1:0]       ph;
  logic [TRK_W-1:0] trk, trk_q;
  logic             re, we, wc, wc0;
  logic [TRK_W-1:0] tq[$];
  logic [31:0]      seed = 32'hbe4dee78;
  int               n_mismatch = 0;
  int               cmp_count = 0;
  int               n, w;

  always #25 clk = ~clk;
  assign pins = {h_sel, ua, sep, h_stp, h_dir, h_wd, h_wg, side0, idx_n, idx_n, dsk_n, ntc_n, two_n};

  ddi_host_model u_host (.clk_i(clk), .sel_n_o(h_sel), .step_n_o(h_stp), .dir_o(h_dir),
                         .wdata_n_o(h_wd), .wgate_n_o(h_wg));
  ddi_top #(.IDX_BASE_CYC_P(IB), .IDX_SEP_CYC_P(IS), .SECTOR_CYC_P(SC), .POR_CYC_P(50),
            .ROT_TMO_CYC_P(500)) u_dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .PINS_I(pins), .STATUS_O(st), .HEAD_LOAD_O(ctl[3]),
    .STEPPER_PWR_O(ctl[2]), .STEP_PHASE_O(ph), .TRACK_O(trk), .ACTIVITY_INDICATOR_O(ctl[1]),
    .DOOR_LOCK_O(ctl[0]), .READ_ENABLE_O(re), .WRITE_ENABLE_O(we), .WRITE_CURRENT_O(wc));

  // ****************************************************
  // Spindle: index and sector holes every 200 cycles
  // ****************************************************
  always begin
    repeat (196) @(posedge clk);
    idx_n <= dsk_n;
    repeat (4) @(posedge clk);
    idx_n <= 1'b1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic pw(input bit s, output int n);
    int k = 0;
    n = 0;
    while ((s ? st.sector_n : st.index_n) === 1'b0 && k < 400) begin
      @(negedge clk);
      k++;
    end
    while ((s ? st.sector_n : st.index_n) !== 1'b0 && k < 400) begin
      @(negedge clk);
      k++;
    end
    while ((s ? st.sector_n : st.index_n) === 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************************
  // Track monitor: every change must match the oldest note
  // ****************************************************
  always @(negedge clk) begin
    if (rst_n === 1'b1 && trk !== trk_q) begin
      if (tq.size() == 0) cmp("track unexpected", 32'(trk_q), 32'(trk));
      else cmp("track", 32'(tq.pop_front()), 32'(trk));
    end
    trk_q <= trk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    seed = lfsr(seed);
    ua <= seed[1:0];
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    u_host.drive(~(4'h1 << ua), 1'b0);
    repeat (12) @(negedge clk);
    cmp("status reset", 32'h1d, 32'(st));
    cmp("write in hold", 0, 32'(we));
    repeat (60) @(posedge clk);
    #1 cmp("write enable", 1, 32'(we));
    $display("test reset done");
    wc0 = wc;
    u_host.wr_edge();
    #1 cmp("write current", {31'h0, ~wc0}, 32'(wc));
    u_host.do_step(1'b0);
    ntc_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1 cmp("lock", 0, 32'(st.wr_lock_n));
    cmp("write locked", 0, 32'(we));
    wc0 = wc;
    u_host.wr_edge();
    #1 cmp("current locked", 32'(wc0), 32'(wc));
    ntc_n <= 1'b1;
    u_host.drive(~(4'h1 << ua), 1'b1);
    repeat (8) @(posedge clk);
    #1 cmp("read enable", 1, 32'(re));
    $display("test write done");
    repeat (450) @(posedge clk);
    #1 cmp("ready", 0, 32'(st.ready_n));
    side0 <= 1'b0;
    repeat (8) @(posedge clk);
    #1 cmp("ready side1 single", 1, 32'(st.ready_n));
    two_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1 cmp("ready side1 double", 0, 32'(st.ready_n));
    side0 <= 1'b1;
    pw(1'b0, w);
    cmp("index width", IB, w);
    sep <= 1'b1;
    pw(1'b0, w);
    pw(1'b0, w);
    cmp("index sep width", IS, w);
    pw(1'b1, w);
    cmp("sector width", SC, w);
    sep <= 1'b0;
    $display("test status done");
    seed = lfsr(seed);
    n = int'(seed[2:0]) + 1;
    for (int i = 1; i <= n; i++) begin
      tq.push_back(TRK_W'(i));
      u_host.do_step(1'b0);
    end
    #1 cmp("track00 off", 1, 32'(st.track00_n));
    for (int i = n - 1; i >= -1; i--) begin
      if (i >= 0) tq.push_back(TRK_W'(i));
      u_host.do_step(1'b1);
    end
    #1 cmp("phase", 0, 32'(ph));
    cmp("track00 on", 0, 32'(st.track00_n));
    cmp("selected ctl", 32'hf, 32'(ctl));
    dsk_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1 cmp("ready no disk", 1, 32'(st.ready_n));
    $display("test step done");
    u_host.drive(~(4'h1 << (ua + 2'h1)), 1'b1);
    u_host.do_step(1'b0);
    #1 cmp("wrong select ctl", 0, 32'(ctl));
    cmp("wrong select status", 32'h1f, 32'(st));
    cmp("notes left", 0, tq.size());
    $display("test select done");
    stop_test();
  end
endmodule
`default_nettype wire
